// [hdl/asf_pkg.sv]
// Functional notes
// - samples are 14-bit two's complement, left-justified
// - fifo off: current sample; on: oldest entry
// - fast read burst skips low-byte registers
// - direct low-byte read returns low bits with fifo off
// - fifo on: 0x01 head data, 0x02-0x06 zero
// - status and outputs auto-increment 0x00 to 0x06; fifo on parks at 0x01
// - high byte bits 13:6, low byte 5:0 upper
// - mode: off, circular, stop, trigger
// - flush on disable, rate change, standby-to-active
// - writing mode 00 clears overflow, watermark, count
// - overflow flag set when count reaches 32
// - watermark flag when count >= level, 0 disables
// - trigger mode keeps up to 32 pre-trigger samples
// - watermark never stops sample storage
// - one sample taken per output rate period
// - fifo read pops oldest, count minus one
// - partial burst discards rest of sample
// - trigger: circular until event, then stop full
// - highpass select chooses filtered or raw data
// - range select sets sensitivity, 11 reserved
// - cutoff select picks highpass cutoff frequency
// - hold-on-sleep keeps fifo, flags gate error, stops
package asf_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_HIGH = 8'h01;
  localparam logic [7:0] ADDR_X_LOW = 8'h02;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
  localparam logic [7:0] ADDR_Y_LOW = 8'h04;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
  localparam logic [7:0] ADDR_Z_LOW = 8'h06;
  localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_FORMAT_CONFIG = 8'h0E;
  localparam logic [7:0] ADDR_HIGHPASS_CONFIG = 8'h0F;
  localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] HIGHPASS_CONFIG_RESET = 8'h00;
  localparam int MODE_LSB = 6;
  localparam int HPF_OUT_BIT = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] FIFO_FULL = 6'h20;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CIRCULAR = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;
  typedef enum logic [1:0] {ASF_AXIS_X, ASF_AXIS_Y, ASF_AXIS_Z} asf_axis_t;
endpackage

// [hdl/asf_sample_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module asf_sample_fifo
  import asf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port, one byte per access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic burst_start,
  input wire logic burst_end,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] next_addr,
  // system control and sample source
  input wire logic fast_read,
  input wire logic system_active,
  input wire logic auto_sleep,
  input wire logic rate_change,
  input wire logic hold_on_sleep,
  input wire logic sample_strobe,
  input wire logic trigger_event,
  input wire logic [13:0] x_axis_sample,
  input wire logic [13:0] y_axis_sample,
  input wire logic [13:0] z_axis_sample,
  input wire logic [13:0] x_filtered,
  input wire logic [13:0] y_filtered,
  input wire logic [13:0] z_filtered,
  input wire logic [7:0] sample_ready_state_reg,
  // status and configuration out
  output logic [5:0] fifo_count,
  output logic fifo_overflow,
  output logic fifo_watermark,
  output logic fifo_triggered,
  output logic gate_error,
  output logic highpass_out,
  output logic [1:0] range_sel,
  output logic [1:0] cutoff_sel
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] fifo_control;
  logic [7:0] sample_format_config;
  logic [7:0] highpass_cutoff_config;
  logic [1:0] fifo_mode;
  logic [5:0] watermark_level;
  logic active_q;
  logic sleep_q;
  logic flush;

  assign fifo_mode = fifo_control[MODE_LSB +: 2];
  assign watermark_level = fifo_control[5:0];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fifo_control <= FIFO_CONTROL_RESET;
      sample_format_config <= FORMAT_CONFIG_RESET;
      highpass_cutoff_config <= HIGHPASS_CONFIG_RESET;
    end else if (reg_wr) begin
      // reserved bits are dropped here so a read back shows what took effect
      case (reg_addr)
        ADDR_FIFO_CONTROL: begin
          fifo_control <= reg_wdata;
        end
        ADDR_FORMAT_CONFIG: begin
          sample_format_config <= reg_wdata & 8'h13;
        end
        ADDR_HIGHPASS_CONFIG: begin
          highpass_cutoff_config <= reg_wdata & 8'h33;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration copies for the analog path
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      highpass_out <= 1'b0;
    end else begin
      highpass_out <= sample_format_config[HPF_OUT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      range_sel <= 2'h0;
    end else begin
      range_sel <= sample_format_config[1:0];
    end
  end

  // the cutoff table itself lives with the filter; only the code is exported
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cutoff_sel <= 2'h0;
    end else begin
      cutoff_sel <= highpass_cutoff_config[1:0];
    end
  end

  // ----------------------------------------
  // power-mode tracking and flush
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= system_active;
    end
  end

  // a rising auto_sleep marks sleep entry for the gate and the flush exemption
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= auto_sleep;
    end
  end

  // a held fifo survives the sleep-entry rate change so the host can drain it
  assign flush = (fifo_mode == MODE_OFF) || (system_active && !active_q) ||
                 (rate_change && !(hold_on_sleep && auto_sleep && !sleep_q));

  // ----------------------------------------
  // sample storage
  // ----------------------------------------
  logic [41:0] mem [FIFO_DEPTH];
  logic [4:0] rd_ptr;
  logic [4:0] wr_ptr;
  logic [41:0] current;
  logic [41:0] head;
  logic [41:0] live;
  logic pop;
  logic push;
  logic drop_old;
  logic fifo_on;
  logic head_rd;
  logic [2:0] fifo_byte;

  assign fifo_on = fifo_mode != MODE_OFF;
  assign live = sample_format_config[HPF_OUT_BIT] ?
                {x_filtered, y_filtered, z_filtered} :
                {x_axis_sample, y_axis_sample, z_axis_sample};
  assign head = mem[rd_ptr];
  // stop mode and post-trigger mode refuse samples once full
  assign push = sample_strobe && fifo_on && !gate_error && !flush &&
                (fifo_count != FIFO_FULL || fifo_mode == MODE_CIRCULAR ||
                 (fifo_mode == MODE_TRIGGER && !fifo_triggered));
  // circular overflow: the oldest entry leaves as the new one lands
  assign drop_old = push && fifo_count == FIFO_FULL;
  // with the fifo on, every read of 0x01 walks the buffer, but only a sample's first byte pops it
  assign head_rd = reg_rd && fifo_on && reg_addr == ADDR_X_HIGH;
  assign pop = head_rd && fifo_byte == 3'h0 && fifo_count != 6'h00 &&
               !(push && drop_old);

  // no reset on the array: a flush only moves the pointers
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= live;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      current <= '0;
    end else if (sample_strobe) begin
      // follows every strobe, so turning the fifo off shows fresh data at once
      current <= live;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || flush) begin
      rd_ptr <= 5'h00;
      wr_ptr <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop || drop_old) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
    end
  end

  // a full buffer has equal pointers, so the count is kept on its own
  always_ff @(posedge sys_clk) begin
    if (!reset_n || flush) begin
      fifo_count <= 6'h00;
    end else begin
      case ({push && !drop_old, pop})
        2'b10: fifo_count <= fifo_count + 6'h01;
        2'b01: fifo_count <= fifo_count - 6'h01;
        default: fifo_count <= fifo_count;
      endcase
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n || fifo_mode == MODE_OFF) begin
      fifo_overflow <= 1'b0;
    end else if (fifo_count == FIFO_FULL) begin
      fifo_overflow <= 1'b1;
    end else if (flush) begin
      fifo_overflow <= 1'b0;
    end
  end

  // one cycle behind the count it compares
  always_ff @(posedge sys_clk) begin
    if (!reset_n || fifo_mode == MODE_OFF) begin
      fifo_watermark <= 1'b0;
    end else begin
      fifo_watermark <= watermark_level != 6'h00 &&
                        fifo_count >= watermark_level;
    end
  end

  // trigger latch: once trigger_event is seen, pushes stop at full instead of dropping the oldest
  always_ff @(posedge sys_clk) begin
    if (!reset_n || fifo_mode == MODE_OFF) begin
      fifo_triggered <= 1'b0;
    end else if (fifo_mode == MODE_TRIGGER && trigger_event) begin
      fifo_triggered <= 1'b1;
    end else if (flush) begin
      fifo_triggered <= 1'b0;
    end
  end

  // held until the host has drained the buffer or turned it off
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gate_error <= 1'b0;
    end else if (hold_on_sleep && fifo_on && auto_sleep && !sleep_q) begin
      gate_error <= 1'b1;
    end else if (fifo_count == 6'h00 || !fifo_on) begin
      gate_error <= 1'b0;
    end
  end

  // ----------------------------------------
  // read data and address sequencing
  // ----------------------------------------
  function automatic logic [7:0] axis_byte(input logic [13:0] s, input logic high);
    axis_byte = high ? s[13:6] : {s[5:0], 2'b00};
  endfunction

  logic [41:0] src;
  logic [1:0] axis_pos;
  logic [7:0] next_rdata;
  logic [7:0] next_step;
  asf_axis_t axis;

  // the fifo head is handed out high then low byte per axis, x, y, z; fast read gives the three high bytes
  assign src = fifo_on ? head : current;
  assign axis_pos = 2'(({1'b0, reg_addr[2:0]} - 4'h1) >> 1);
  assign axis = (axis_pos == 2'h0) ? ASF_AXIS_X : (axis_pos == 2'h1) ? ASF_AXIS_Y : ASF_AXIS_Z;

  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      ADDR_STATUS: next_rdata = sample_ready_state_reg;
      ADDR_X_HIGH, ADDR_X_LOW, ADDR_Y_HIGH, ADDR_Y_LOW, ADDR_Z_HIGH, ADDR_Z_LOW: begin
        if (fifo_on && reg_addr != ADDR_X_HIGH) begin
          next_rdata = 8'h00;
        end else begin
          case (axis)
            ASF_AXIS_X: next_rdata = axis_byte(src[41:28], reg_addr[0]);
            ASF_AXIS_Y: next_rdata = axis_byte(src[27:14], reg_addr[0]);
            ASF_AXIS_Z: next_rdata = axis_byte(src[13:0], reg_addr[0]);
            default: next_rdata = 8'h00;
          endcase
        end
      end
      ADDR_FIFO_CONTROL: next_rdata = fifo_control;
      ADDR_FORMAT_CONFIG: next_rdata = sample_format_config;
      ADDR_HIGHPASS_CONFIG: next_rdata = highpass_cutoff_config;
      default: next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // fifo burst walk
  // ----------------------------------------
  // fifo bytes within one sample, so a burst can walk a whole sample at 0x01
  logic [41:0] burst_sample;
  logic [7:0] fifo_rdata;

  always_comb begin
    fifo_rdata = 8'h00;
    case (fifo_byte)
      3'h0: fifo_rdata = axis_byte(head[41:28], 1'b1);
      3'h1: fifo_rdata = fast_read ? axis_byte(burst_sample[27:14], 1'b1) :
                                     axis_byte(burst_sample[41:28], 1'b0);
      3'h2: fifo_rdata = fast_read ? axis_byte(burst_sample[13:0], 1'b1) :
                                     axis_byte(burst_sample[27:14], 1'b1);
      3'h3: fifo_rdata = axis_byte(burst_sample[27:14], 1'b0);
      3'h4: fifo_rdata = axis_byte(burst_sample[13:0], 1'b1);
      3'h5: fifo_rdata = axis_byte(burst_sample[13:0], 1'b0);
      default: fifo_rdata = 8'h00;
    endcase
  end

  always_comb begin
    next_step = reg_addr + 8'h01;
    if (fast_read && reg_addr >= ADDR_X_HIGH && reg_addr < ADDR_Z_HIGH) begin
      next_step = reg_addr + 8'h02;
    end else if (fast_read && reg_addr == ADDR_Z_HIGH) begin
      next_step = ADDR_STATUS;
    end else if (reg_addr == ADDR_Z_LOW) begin
      next_step = ADDR_STATUS;
    end
    // with the fifo on the address parks at 0x01 so bursts drain sample by sample
    if (fifo_on && reg_addr == ADDR_X_HIGH) begin
      next_step = ADDR_X_HIGH;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || burst_start || burst_end) begin
      fifo_byte <= 3'h0;
    end else if (head_rd) begin
      fifo_byte <= (fifo_byte == (fast_read ? 3'h2 : 3'h5)) ? 3'h0 : fifo_byte + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      burst_sample <= '0;
    end else if (pop && fifo_byte == 3'h0) begin
      burst_sample <= head;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // the sample is popped on its first byte; unread y and z parts are lost
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (head_rd) begin
      reg_rdata <= (fifo_byte == 3'h0 && fifo_count == 6'h00) ? 8'h00 : fifo_rdata;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      next_addr <= 8'h00;
    end else if (reg_rd) begin
      next_addr <= next_step;
    end
  end

endmodule
`default_nettype wire

// [sim/asf_host.sv]
`timescale 1ns/1ns
`default_nettype none
module asf_host
  import asf_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output logic reg_rd,
  output logic reg_wr,
  output logic burst_start,
  output logic burst_end,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    {reg_rd, reg_wr, burst_start, burst_end} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines carry the inverse so stale values never look valid
  task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_rd <= !wr;
    reg_wr <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask
  task automatic mark(input logic first);
    @(posedge sys_clk);
    burst_start <= first;
    burst_end <= !first;
    @(posedge sys_clk);
    {burst_start, burst_end} <= 2'h0;
  endtask
  task automatic set_mode(input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, ADDR_FIFO_CONTROL, 8'h00, q);
    xfer(1'b1, ADDR_FIFO_CONTROL, d, q);
  endtask
endmodule
`default_nettype wire

// [sim/asf_sample_fifo_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module asf_sample_fifo_asserts
  import asf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] next_addr,
  // fifo side
  input wire logic fast_read,
  input wire logic sample_strobe,
  input wire logic [5:0] fifo_count,
  input wire logic fifo_overflow,
  input wire logic fifo_watermark,
  input wire logic [1:0] range_sel
);
  // ----
  // shadow of the fifo control register
  // ----
  logic [1:0] mode_q;
  logic [5:0] wm_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_q <= MODE_OFF;
      wm_q <= 6'h00;
    end else if (reg_wr && reg_addr == ADDR_FIFO_CONTROL) begin
      mode_q <= reg_wdata[7:6];
      wm_q <= reg_wdata[5:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_low_rd;
    reg_rd && mode_q != MODE_OFF && reg_addr inside {[ADDR_X_LOW:ADDR_Z_LOW]};
  endsequence
  sequence s_x_rd;
    reg_rd && mode_q == MODE_OFF && reg_addr == ADDR_X_HIGH;
  endsequence
  a_count_cap: assert property (fifo_count <= FIFO_FULL)
    else $error("count above depth");
  a_ovf_full: assert property (fifo_count == FIFO_FULL |-> ##[0:1] fifo_overflow)
    else $error("no overflow at full");
  a_grow_strobe: assert property (
    fifo_count > $past(fifo_count) |-> $past(sample_strobe))
    else $error("count grew without sample");
  a_step_one: assert property (
    fifo_count != $past(fifo_count) |-> fifo_count == 6'h00 ||
    fifo_count == $past(fifo_count) + 6'h01 || fifo_count == $past(fifo_count) - 6'h01)
    else $error("count jumped");
  a_clear_off: assert property (
    reg_wr && reg_addr == ADDR_FIFO_CONTROL && reg_wdata[7:6] == MODE_OFF
    |=> ##1 fifo_count == 6'h00 && !fifo_overflow && !fifo_watermark)
    else $error("disable did not clear status");
  a_fast_skip: assert property (
    s_x_rd |=> next_addr == ($past(fast_read) ? ADDR_Y_HIGH : ADDR_X_LOW))
    else $error("wrong next address");
  a_low_zero: assert property (s_low_rd |=> reg_rdata == 8'h00)
    else $error("low byte not zero in fifo mode");
  a_wmrk_level: assert property (
    mode_q != MODE_OFF && wm_q != 6'h00 && $stable(wm_q) &&
    $past(fifo_count) >= wm_q && fifo_count >= wm_q |-> fifo_watermark)
    else $error("watermark flag missing");
  a_range_copy: assert property (
    reg_wr && reg_addr == ADDR_FORMAT_CONFIG |=> ##1 range_sel == $past(reg_wdata[1:0], 2))
    else $error("range select not updated");
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import asf_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic fast_read = 1'b0, system_active = 1'b0, auto_sleep = 1'b0, rate_change = 1'b0;
  logic hold_on_sleep = 1'b0, sample_strobe = 1'b0, trigger_event = 1'b0;
  logic [13:0] xs = 14'h0000;
  logic reg_rd, reg_wr, burst_start, burst_end, fifo_overflow, fifo_watermark;
  logic fifo_triggered, gate_error, highpass_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, next_addr, q;
  logic [5:0] fifo_count;
  logic [1:0] range_sel, cutoff_sel;
  int fail_count = 0, checks_done = 0, cycles = 0;
  always #50 sys_clk = ~sys_clk;
  asf_host host_i (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .burst_start(burst_start), .burst_end(burst_end), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  asf_sample_fifo asf_sample_fifo_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .burst_start(burst_start), .burst_end(burst_end), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .next_addr(next_addr),
    .fast_read(fast_read), .system_active(system_active), .auto_sleep(auto_sleep),
    .rate_change(rate_change), .hold_on_sleep(hold_on_sleep), .sample_strobe(sample_strobe),
    .trigger_event(trigger_event), .x_axis_sample(xs), .y_axis_sample(xs ^ 14'h0F0F),
    .z_axis_sample(xs ^ 14'h3333), .x_filtered(~xs), .y_filtered(~(xs ^ 14'h0F0F)),
    .z_filtered(~(xs ^ 14'h3333)), .sample_ready_state_reg(8'hC3),
    .fifo_count(fifo_count), .fifo_overflow(fifo_overflow), .fifo_watermark(fifo_watermark),
    .fifo_triggered(fifo_triggered), .gate_error(gate_error), .highpass_out(highpass_out),
    .range_sel(range_sel), .cutoff_sel(cutoff_sel));
  function automatic logic [13:0] smp(input logic [7:0] k);
    return {k[5:0], 8'h5A};
  endfunction
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    host_i.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic push(input int n, input logic [7:0] k0);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      xs <= smp(k0 + 8'(i));
      sample_strobe <= 1'b1;
      @(posedge sys_clk);
      sample_strobe <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // this task writes the watermark only in standby; t_modes clears it while active
  task automatic mode(input logic [7:0] d);
    @(posedge sys_clk);
    system_active <= 1'b0;
    host_i.set_mode(d);
    @(posedge sys_clk);
    system_active <= 1'b1;
  endtask
  task automatic burst1(input logic [7:0] k);
    logic [13:0] s;
    s = smp(k);
    host_i.mark(1'b1);
    rd(ADDR_X_HIGH, s[13:6]);
    host_i.mark(1'b0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(ADDR_FIFO_CONTROL, FIFO_CONTROL_RESET);
    rd(ADDR_FORMAT_CONFIG, FORMAT_CONFIG_RESET);
    rd(ADDR_HIGHPASS_CONFIG, HIGHPASS_CONFIG_RESET);
    rd(8'h0A, 8'h00);
    host_i.xfer(1'b1, ADDR_FORMAT_CONFIG, 8'h12, q);
    host_i.xfer(1'b1, ADDR_HIGHPASS_CONFIG, 8'h03, q);
    rd(ADDR_FORMAT_CONFIG, 8'h12);
    chk({highpass_out, range_sel, 3'h0, cutoff_sel}, 8'hC3);
  endtask
  task automatic t_direct();
    logic [13:0] s;
    s = smp(8'h07);
    push(1, 8'h07);
    rd(ADDR_X_HIGH, ~s[13:6]);
    host_i.xfer(1'b1, ADDR_FORMAT_CONFIG, 8'h00, q);
    push(1, 8'h07);
    rd(ADDR_STATUS, 8'hC3);
    rd(ADDR_X_HIGH, s[13:6]);
    rd(ADDR_X_LOW, {s[5:0], 2'b00});
    s = s ^ 14'h0F0F;
    rd(ADDR_Y_HIGH, s[13:6]);
    @(posedge sys_clk);
    fast_read <= 1'b1;
    rd(ADDR_Y_LOW, {s[5:0], 2'b00});
    host_i.xfer(1'b0, ADDR_X_HIGH, 8'h00, q);
    chk(next_addr, ADDR_Y_HIGH);
    @(posedge sys_clk);
    fast_read <= 1'b0;
  endtask
  task automatic t_fifo();
    logic [13:0] s;
    mode(8'h44);
    push(5, 8'h00);
    chk({1'b0, fifo_watermark, fifo_count}, 8'h45);
    host_i.mark(1'b1);
    for (int i = 0; i < 6; i++) begin
      s = smp(8'h00) ^ ((i < 2) ? 14'h0000 : (i < 4) ? 14'h0F0F : 14'h3333);
      rd(ADDR_X_HIGH, i[0] ? {s[5:0], 2'b00} : s[13:6]);
    end
    host_i.mark(1'b0);
    chk(8'(fifo_count), 8'h04);
    rd(ADDR_Y_LOW, 8'h00);
    burst1(8'h01);
    burst1(8'h02);
    @(posedge sys_clk);
    fast_read <= 1'b1;
    host_i.mark(1'b1);
    for (int i = 0; i < 3; i++) begin
      s = smp(8'h03) ^ ((i == 0) ? 14'h0000 : (i == 1) ? 14'h0F0F : 14'h3333);
      rd(ADDR_X_HIGH, s[13:6]);
    end
    chk(next_addr, ADDR_X_HIGH);
    host_i.mark(1'b0);
    fast_read <= 1'b0;
    @(posedge sys_clk);
    rate_change <= 1'b1;
    @(posedge sys_clk);
    rate_change <= 1'b0;
    #1 chk(8'(fifo_count), 8'h00);
  endtask
  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      mode({m[1:0], 6'h00});
      push(40, 8'h00);
      if (m == 3) begin
        @(posedge sys_clk);
        trigger_event <= 1'b1;
        @(posedge sys_clk);
        trigger_event <= 1'b0;
        push(3, 8'h28);
        chk(8'(fifo_triggered), 8'h01);
      end
      chk({fifo_overflow, fifo_watermark, fifo_count}, 8'hA0);
      burst1((m == 2) ? 8'h00 : 8'h08);
    end
    host_i.xfer(1'b1, ADDR_FIFO_CONTROL, 8'h00, q);
    @(posedge sys_clk);
    #1 chk({fifo_overflow, fifo_watermark, fifo_count}, 8'h00);
  endtask
  task automatic t_gate();
    mode(8'h40);
    push(3, 8'h00);
    @(posedge sys_clk);
    hold_on_sleep <= 1'b1;
    auto_sleep <= 1'b1;
    push(2, 8'h03);
    chk({gate_error, 1'b0, fifo_count}, 8'h83);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_direct();
    t_fifo();
    t_modes();
    t_gate();
    stop_test();
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
endmodule
bind asf_sample_fifo asf_sample_fifo_asserts asf_chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .next_addr(next_addr), .fast_read(fast_read),
  .sample_strobe(sample_strobe), .fifo_count(fifo_count), .fifo_overflow(fifo_overflow),
  .fifo_watermark(fifo_watermark), .range_sel(range_sel));
`default_nettype wire
